// ===== rtl/mic_gap_timer.sv
// Timer that holds the interrupt released for the retrigger gap
`timescale 1ns/100ps
module mic_gap_timer (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  mic_gap_if.tmr gap
);
  import mic_pkg::*;

  typedef struct packed {
    logic [MIC_GAP_W-1:0] cnt;
  } mic_gap_state_t;

  mic_gap_state_t q;
  mic_gap_state_t d;

  // A new start reloads; otherwise count down to zero
  always_comb begin
    d = q;
    if (gap.start) begin
      d.cnt = MIC_GAP_LOAD;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // Busy while counting, start cycle excluded
  assign gap.busy = (q.cnt != '0);
endmodule // mic_gap_timer

// ===== rtl/mic_sync2.sv
// Two-stage synchroniser for the serial bus pins
`timescale 1ns/100ps
module mic_sync2 (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);
  import mic_pkg::*;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } mic_sync_state_t;

  mic_sync_state_t q;
  mic_sync_state_t d;

  // Stage one feeds only stage two
  always_comb begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
  end

  // Idle bus level after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      q.s1 <= MIC_SYNC_RST;
      q.s2 <= MIC_SYNC_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign sync_o = q.s2;
endmodule // mic_sync2

// ===== rtl/mic_top.sv
// Mode, enable and interrupt status control with its serial register port
// What this block does
// - Clearing one flag while another pends releases interrupt 50 us, then reasserts.
// - Mode bit 7 low selects standby; only serial, GPIO, key scan remain.
// - Mode bit 7 high selects operating; backlight and sensor functions permitted.
// - Mode bit 6 enables the backlight driver when one.
// - Software-set dim bit keeps backlight dim until software clears it.
// - Expiry of a non-zero dim timer sets the dim bit itself.
// - Status bit 4 sets on overvoltage; cleared by writing one.
// - Status bit 3 sets on light comparator trigger; cleared by writing one.
// - Status bit 2 flags GPIO input; clears after GPIO status cleared.
// - Status bit 1 flags key release; clears after release status cleared.
// - Status bit 0 flags key press; clears after press status cleared.
// - Autoload on: dummy load when code below 8 linear or 32 square.
// - Enable bit 3 gates light comparator events onto the interrupt.
// - Enable bits 2 and 1 gate overvoltage and key release events.
// - Enable bit 0 gates key press events onto the interrupt.
// - All bits reset to zero; unused bits read as zero.
// - Writes: address byte 0x64, register, data; each byte acknowledged.
// - Reads: register under 0x64, repeated start 0x65, one byte, no ack.
`timescale 1ns/100ps
module mic_top (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic int_o,
  output logic int_oe,
  input wire logic overvoltage_detect,
  input wire logic light_comparator_event,
  input wire logic gpio_stat_pending,
  input wire logic key_release_pending,
  input wire logic key_press_pending,
  input wire logic [3:0] dim_timer_field,
  input wire logic dim_timer_expired,
  input wire logic [6:0] backlight_code,
  input wire logic [1:0] backlight_law,
  output logic operating_mode_select,
  output logic backlight_driver_enable,
  output logic dim_mode,
  output logic dummy_load_on
);
  import mic_pkg::*;

  typedef struct packed {
    mic_pkg::mic_i2c_st_t st;
    mic_pkg::mic_i2c_st_t nxt;
    logic drv;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    logic op_mode;
    logic bl_drv;
    logic dim;
    logic [MIC_FLAG_W-1:0] flags;
    logic [MIC_IEN_W-1:0] ien;
    logic irq_oe;
    logic dload;
  } mic_top_state_t;

  mic_top_state_t q;
  mic_top_state_t d;

  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rx;
  logic [7:0] rd_byte;
  logic [MIC_FLAG_W-1:0] set_v;
  logic [MIC_FLAG_W-1:0] lower_v;
  logic [MIC_FLAG_W-1:0] mask_v;
  logic gap_start;
  logic law_low;

  mic_gap_if gap_if ();

  // Bus pins cross into the clock domain
  mic_sync2 u_sync (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );

  // Release gap after a clear with another interrupt pending
  mic_gap_timer u_gap (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .gap(gap_if.tmr)
  );

  assign gap_if.start = gap_start;

  // Bus conditions from the synchronised levels
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s & ~q.scl_d;
  assign scl_fall = ~scl_s & q.scl_d;
  assign start_c = q.scl_d & scl_s & q.sda_d & ~sda_s;
  assign stop_c = q.scl_d & scl_s & ~q.sda_d & sda_s;
  assign rx = {q.sh[6:0], sda_s};

  // Register read view; unused bits and unmapped offsets read zero
  always_comb begin
    if (q.ptr == MIC_REG_MODE) begin
      rd_byte = {q.op_mode, q.bl_drv, q.dim, q.flags};
    end else if (q.ptr == MIC_REG_IEN) begin
      rd_byte = {3'h0, q.ien};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Event sources, lower-level holds and interrupt gating per flag
  always_comb begin
    set_v = '0;
    set_v[MIC_F_OVERV] = overvoltage_detect;
    set_v[MIC_F_LIGHT] = light_comparator_event;
    set_v[MIC_F_GPIO] = gpio_stat_pending;
    set_v[MIC_F_KREL] = key_release_pending;
    set_v[MIC_F_KPRS] = key_press_pending;
    lower_v = '0;
    lower_v[MIC_F_GPIO] = gpio_stat_pending;
    lower_v[MIC_F_KREL] = key_release_pending;
    lower_v[MIC_F_KPRS] = key_press_pending;
    mask_v = '0;
    mask_v[MIC_F_OVERV] = q.ien[MIC_E_OVERV];
    mask_v[MIC_F_LIGHT] = q.ien[MIC_E_LIGHT];
    mask_v[MIC_F_GPIO] = 1'b1;
    mask_v[MIC_F_KREL] = q.ien[MIC_E_KREL];
    mask_v[MIC_F_KPRS] = q.ien[MIC_E_KPRS];
  end

  // Backlight code under the threshold of the selected law
  always_comb begin
    law_low = 1'b0;
    if (backlight_law == MIC_LAW_LINEAR) begin
      law_low = (backlight_code < MIC_LOAD_LIN_LIM);
    end else if (backlight_law == MIC_LAW_SQUARE) begin
      law_low = (backlight_code < MIC_LOAD_SQR_LIM);
    end
  end

  // Serial engine, register writes, flags and interrupt
  always_comb begin
    logic [MIC_FLAG_W-1:0] w1c;
    logic [MIC_FLAG_W-1:0] clr;
    logic pend;
    w1c = '0;
    clr = '0;
    pend = 1'b0;
    d = q;
    gap_start = 1'b0;
    d.scl_d = scl_s;
    d.sda_d = sda_s;
    if (stop_c) begin
      d.st = MIC_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_c) begin
      d.st = MIC_ADDR;
      d.bcnt = 3'h0;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        MIC_IDLE: begin
          d.sda_oe = 1'b0;
        end
        MIC_ADDR, MIC_REG, MIC_WDATA: begin
          if (scl_rise) begin
            d.sh = rx;
            d.bcnt = q.bcnt + 3'h1;
            if (q.bcnt == MIC_BIT_LAST) begin
              d.st = MIC_ACK;
              d.drv = 1'b0;
              if (q.st == MIC_ADDR) begin
                if (rx == MIC_DEV_WADDR) begin
                  d.nxt = MIC_REG;
                end else if (rx == MIC_DEV_RADDR) begin
                  d.nxt = MIC_RDATA;
                end else begin
                  d.st = MIC_IDLE;
                end
              end else if (q.st == MIC_REG) begin
                d.ptr = rx;
                d.nxt = MIC_WDATA;
              end else begin
                d.ptr = q.ptr + 8'h01;
                d.nxt = MIC_WDATA;
                if (q.ptr == MIC_REG_MODE) begin
                  d.op_mode = rx[MIC_B_OPMODE];
                  d.bl_drv = rx[MIC_B_BLDRV];
                  d.dim = rx[MIC_B_DIM];
                  w1c = rx[MIC_FLAG_W-1:0];
                end else if (q.ptr == MIC_REG_IEN) begin
                  d.ien = rx[MIC_IEN_W-1:0];
                end
              end
            end
          end
        end
        MIC_ACK: begin
          if (scl_fall) begin
            if (!q.drv) begin
              d.sda_oe = 1'b1;
              d.drv = 1'b1;
            end else begin
              d.st = q.nxt;
              d.bcnt = 3'h0;
              d.sh = rd_byte;
              d.sda_oe = (q.nxt == MIC_RDATA) & ~rd_byte[7];
            end
          end
        end
        MIC_RDATA: begin
          if (scl_fall) begin
            if (q.bcnt == MIC_BIT_LAST) begin
              d.sda_oe = 1'b0;
              d.st = MIC_MACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
              d.bcnt = q.bcnt + 3'h1;
            end
          end
        end
        MIC_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              d.st = MIC_IDLE;
            end else begin
              d.ptr = q.ptr + 8'h01;
              d.st = MIC_ACK;
              d.drv = 1'b1;
              d.nxt = MIC_RDATA;
            end
          end
        end
        default: begin
          d.st = MIC_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
    // Timer expiry sets dim mode, winning over a same-cycle write
    if (dim_timer_expired && (dim_timer_field != 4'h0)) begin
      d.dim = 1'b1;
    end
    // Write-one clears, held off by pending lower status; set wins
    clr = w1c & ~lower_v;
    d.flags = (q.flags & ~clr) | set_v;
    pend = |(d.flags & mask_v);
    if ((|(q.flags & ~d.flags)) && pend) begin
      gap_start = 1'b1;
    end
    d.irq_oe = pend & ~gap_start & ~gap_if.busy;
    d.dload = q.ien[MIC_E_DLOAD] & q.op_mode & q.bl_drv & law_low;
  end

  // State register; reset clears all but st, nxt (MIC_IDLE) and scl_d, sda_d (high)
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
      q.st <= MIC_IDLE;
      q.nxt <= MIC_IDLE;
      q.ptr <= MIC_PTR_RST;
      q.flags <= MIC_FLAGS_RST;
      q.ien <= MIC_IEN_RST;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // Open-drain pins only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = q.sda_oe;
  assign int_o = 1'b0;
  assign int_oe = q.irq_oe;

  // Backlight driver and dummy load need operating mode; dim mode does not
  assign operating_mode_select = q.op_mode;
  assign backlight_driver_enable = q.op_mode & q.bl_drv;
  assign dim_mode = q.dim;
  assign dummy_load_on = q.dload;
endmodule // mic_top

// ===== shared/mic_gap_if.sv
// Handshake between the interrupt logic and the release gap timer
`timescale 1ns/100ps
interface mic_gap_if;
  logic start;
  logic busy;
  modport ctl (output start, input busy);
  modport tmr (input start, output busy);
endinterface

// ===== shared/mic_pkg.sv
// Constants and types shared by the mode and interrupt control block
package mic_pkg;
  // Serial bus addresses (8-bit form, direction bit included)
  localparam logic [7:0] MIC_DEV_WADDR = 8'h64;
  localparam logic [7:0] MIC_DEV_RADDR = 8'h65;
  // Register offsets
  localparam logic [7:0] MIC_REG_MODE = 8'h00;
  localparam logic [7:0] MIC_REG_IEN = 8'h01;
  // Mode and status register field positions
  localparam int MIC_B_OPMODE = 7;
  localparam int MIC_B_BLDRV = 6;
  localparam int MIC_B_DIM = 5;
  localparam int MIC_F_OVERV = 4;
  localparam int MIC_F_LIGHT = 3;
  localparam int MIC_F_GPIO = 2;
  localparam int MIC_F_KREL = 1;
  localparam int MIC_F_KPRS = 0;
  localparam int MIC_FLAG_W = 5;
  // Interrupt enable register field positions
  localparam int MIC_E_DLOAD = 4;
  localparam int MIC_E_LIGHT = 3;
  localparam int MIC_E_OVERV = 2;
  localparam int MIC_E_KREL = 1;
  localparam int MIC_E_KPRS = 0;
  localparam int MIC_IEN_W = 5;
  // Values after reset
  localparam logic [4:0] MIC_FLAGS_RST = 5'h00;
  localparam logic [4:0] MIC_IEN_RST = 5'h00;
  localparam logic [7:0] MIC_PTR_RST = 8'h00;
  localparam logic [1:0] MIC_SYNC_RST = 2'h3;
  // Dummy load thresholds per transfer law
  localparam logic [1:0] MIC_LAW_LINEAR = 2'h0;
  localparam logic [1:0] MIC_LAW_SQUARE = 2'h1;
  localparam logic [6:0] MIC_LOAD_LIN_LIM = 7'h08;
  localparam logic [6:0] MIC_LOAD_SQR_LIM = 7'h20;
  // Interrupt release gap: 50 us at 40 MHz
  localparam int MIC_CLK_KHZ = 40000;
  localparam int MIC_GAP_US = 50;
  localparam int MIC_GAP_CYC = MIC_GAP_US * MIC_CLK_KHZ / 1000;
  localparam int MIC_GAP_W = 11;
  localparam logic [10:0] MIC_GAP_LOAD = 11'(MIC_GAP_CYC - 1);
  localparam logic [2:0] MIC_BIT_LAST = 3'h7;
  // Serial engine states
  typedef enum logic [6:0] {
    MIC_IDLE = 7'h01,
    MIC_ADDR = 7'h02,
    MIC_REG = 7'h04,
    MIC_WDATA = 7'h08,
    MIC_RDATA = 7'h10,
    MIC_ACK = 7'h20,
    MIC_MACK = 7'h40
  } mic_i2c_st_t;
endpackage

// ===== tb/mic_host_model.sv
// Host bus master model for the serial register port
`timescale 1ns/100ps
module mic_host_model (
  input wire logic mclk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  import mic_pkg::*;
  // Bus idles released with SCL standing high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Half bit time, changes land just after the edge
  task automatic tick;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  // Start when b is 0, stop when b is 1: SDA moves while SCL is high
  task automatic cond(input logic b);
    sda_low = b;
    tick();
    scl = 1'b1;
    tick();
    sda_low = !b;
    tick();
    scl = b;
  endtask
  // Eight bits MSB first, then a released ninth bit that is sampled
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic b9);
    logic [8:0] b;
    b = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      sda_low = !b[i];
      tick();
      scl = 1'b1;
      tick();
      b[i] = sda;
      scl = 1'b0;
    end
    q = b[8:1];
    b9 = b[0];
  endtask
  // Register write or read, nak set when any acknowledge is wrong
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic nak);
    logic n0, n1, n2, n3;
    cond(1'b0);
    xbyte(MIC_DEV_WADDR, q, n0);
    xbyte(a, q, n1);
    if (rd) begin
      cond(1'b0);
      xbyte(MIC_DEV_RADDR, q, n2);
      xbyte(8'hFF, q, n3);
      n3 = !n3;
    end else begin
      xbyte(d, q, n2);
      n3 = 1'b0;
    end
    cond(1'b1);
    nak = n0 | n1 | n2 | n3;
  endtask
endmodule // mic_host_model

// ===== tb/mic_top_checker.sv
// Port assertions for the mode and interrupt block
`timescale 1ns/100ps
module mic_top_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic int_o,
  input wire logic dim_timer_expired,
  input wire logic [3:0] dim_timer_field,
  input wire logic [6:0] backlight_code,
  input wire logic [1:0] backlight_law,
  input wire logic operating_mode_select,
  input wire logic backlight_driver_enable,
  input wire logic dim_mode,
  input wire logic dummy_load_on
);
  import mic_pkg::*;
  logic scl_q, ok_q;
  logic [3:0] fall_q, rise_q;
  // Cycles since each SCL edge, and whether the load may be on next cycle
  always_ff @(posedge mclk) begin
    scl_q <= scl_i;
    fall_q <= srst ? 4'hF : (scl_q && !scl_i) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hF};
    rise_q <= srst ? 4'hF : (!scl_q && scl_i) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hF};
    ok_q <= backlight_driver_enable && (backlight_law == MIC_LAW_LINEAR ?
      backlight_code < MIC_LOAD_LIN_LIM :
      backlight_law == MIC_LAW_SQUARE && backlight_code < MIC_LOAD_SQR_LIM);
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_od; !sda_o && !int_o; endproperty
  property p_stby; !operating_mode_select |-> !backlight_driver_enable; endproperty
  property p_dim; ce && dim_timer_expired && dim_timer_field != 4'h0 |=> dim_mode; endproperty
  property p_load; dummy_load_on |-> ok_q; endproperty
  property p_dimclr; $fell(dim_mode) |-> rise_q <= 4'h9; endproperty
  property p_op; $rose(operating_mode_select) |-> rise_q <= 4'h9; endproperty
  property p_bl; $rose(backlight_driver_enable) |-> rise_q <= 4'h9; endproperty
  property p_ack; $rose(sda_oe) |-> fall_q inside {[4'h1:4'h5]}; endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  a_stby: assert property (p_stby) else $error("driver on in standby");
  a_dim: assert property (p_dim) else $error("dim timer expiry ignored");
  a_load: assert property (p_load) else $error("dummy load on wrongly");
  a_dimclr: assert property (p_dimclr) else $error("dim dropped unasked");
  a_op: assert property (p_op) else $error("mode rose unasked");
  a_bl: assert property (p_bl) else $error("driver enabled unasked");
  a_ack: assert property (p_ack) else $error("data drive off SCL fall");
  c_load: cover property (dummy_load_on);
  c_dim: cover property ($rose(dim_mode));
  c_ack: cover property ($rose(sda_oe));
endmodule // mic_top_checker

bind mic_top mic_top_checker u_chk (.*);

// ===== tb/tb.sv
// Bench for the mode and interrupt block
`timescale 1ns/100ps
module tb;
  import mic_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic dte = 1'b0;
  logic [4:0] src = 5'h00;
  logic [3:0] dtf = 4'h0;
  logic [6:0] code = 7'h00;
  logic [1:0] law = 2'h0;
  logic ce = 1'b1;
  logic scl, sda_low, sda_oe, int_oe, opm, bde, dim, dload;
  wire sda = !(sda_low || sda_oe);
  int num_errors = 0;
  int checks_done = 0;
  int low_cnt = 0;
  int low_len = 0;
  always #12.5 mclk = !mclk;
  // Length of the latest low spell of the interrupt
  always @(posedge mclk) begin
    low_cnt <= int_oe ? 0 : low_cnt + 1;
    if (int_oe && low_cnt != 0) low_len <= low_cnt;
  end
  mic_top dut (.mclk(mclk), .srst(srst), .ce(ce), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .int_o(), .int_oe(int_oe), .overvoltage_detect(src[4]),
    .light_comparator_event(src[3]), .gpio_stat_pending(src[2]),
    .key_release_pending(src[1]), .key_press_pending(src[0]), .dim_timer_field(dtf),
    .dim_timer_expired(dte), .backlight_code(code), .backlight_law(law),
    .operating_mode_select(opm), .backlight_driver_enable(bde), .dim_mode(dim),
    .dummy_load_on(dload));
  mic_host_model u_host (.mclk(mclk), .scl(scl), .sda_low(sda_low), .sda(sda));
  // Verdict and end of run
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Register access, acknowledges and read data judged
  task automatic rw(input logic r, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic nak;
    u_host.xfer(r, a, d, q, nak);
    check({7'h00, nak}, 8'h00);
    if (r) check(q, d);
  endtask
  // Bounded wait for the interrupt level
  task automatic wait_int(input logic v);
    int n;
    n = 0;
    while (int_oe !== v && n < 4000) begin
      cyc(1);
      n++;
    end
    check({7'h00, int_oe}, {7'h00, v});
    if (n >= 4000) wrap_up();
  endtask
  // Reset values, unused bits and an unmapped offset
  task automatic s_reset;
    rw(0, 8'h1C, 8'hFF);
    rw(1, MIC_REG_MODE, 8'h00);
    rw(1, MIC_REG_IEN, 8'h00);
    rw(1, 8'h1C, 8'h00);
    check({4'h0, opm, bde, dim, int_oe}, 8'h00);
  endtask
  // Standby, operating, driver and dim bits
  task automatic s_mode;
    rw(0, MIC_REG_MODE, 8'hE0);
    rw(1, MIC_REG_MODE, 8'hE0);
    check({5'h00, opm, bde, dim}, 8'h07);
    rw(0, MIC_REG_MODE, 8'h40);
    check({5'h00, opm, bde, dim}, 8'h00);
    rw(0, MIC_REG_MODE, 8'h80);
    check({5'h00, opm, bde, dim}, 8'h04);
  endtask
  task automatic pulse_dim(input logic [3:0] f);
    dtf = f;
    dte = 1'b1;
    cyc(1);
    dte = 1'b0;
    cyc(2);
  endtask
  // Dim timer expiry sets dim only when programmed; dim holds until cleared
  task automatic s_dim;
    pulse_dim(4'h0);
    check({7'h00, dim}, 8'h00);
    pulse_dim(4'h3);
    rw(1, MIC_REG_MODE, 8'hA0);
    check({7'h00, dim}, 8'h01);
    rw(0, MIC_REG_MODE, 8'h80);
    check({7'h00, dim}, 8'h00);
  endtask
  task automatic ld(input logic [1:0] lw, input logic [6:0] c, input logic e);
    law = lw;
    code = c;
    cyc(3);
    check({7'h00, dload}, {7'h00, e});
  endtask
  // Dummy load thresholds per law, and its gating
  task automatic s_load;
    rw(0, MIC_REG_IEN, 8'hFF);
    rw(1, MIC_REG_IEN, 8'h1F);
    rw(0, MIC_REG_IEN, 8'h10);
    rw(0, MIC_REG_MODE, 8'hC0);
    ld(MIC_LAW_LINEAR, 7'h07, 1'b1);
    ld(MIC_LAW_LINEAR, 7'h08, 1'b0);
    ld(MIC_LAW_SQUARE, 7'h1F, 1'b1);
    ld(MIC_LAW_SQUARE, 7'h20, 1'b0);
    ld(2'h2, 7'h00, 1'b0);
    rw(0, MIC_REG_MODE, 8'h80);
    ld(MIC_LAW_LINEAR, 7'h00, 1'b0);
    rw(0, MIC_REG_IEN, 8'h00);
    rw(0, MIC_REG_MODE, 8'hC0);
    ld(MIC_LAW_LINEAR, 7'h00, 1'b0);
    rw(0, MIC_REG_MODE, 8'h00);
  endtask
  // One flag: set, masked (GPIO always enabled), enabled, sticky, blocked clear (flags 2 to 0 only), then cleared
  task automatic s_flag(input int f, input int e);
    rw(0, MIC_REG_IEN, 8'h00);
    src[f] = 1'b1;
    cyc(1);
    if (f > 2) src[f] = 1'b0;
    cyc(3);
    check({7'h00, int_oe}, {7'h00, f == 2});
    rw(1, MIC_REG_MODE, 8'h01 << f);
    if (e >= 0) rw(0, MIC_REG_IEN, 8'h01 << e);
    wait_int(1'b1);
    rw(0, MIC_REG_MODE, 8'h00);
    if (f < 3) rw(0, MIC_REG_MODE, 8'h01 << f);
    rw(1, MIC_REG_MODE, 8'h01 << f);
    src[f] = 1'b0;
    rw(0, MIC_REG_MODE, 8'h01 << f);
    rw(1, MIC_REG_MODE, 8'h00);
    wait_int(1'b0);
  endtask
  // Clearing one flag while another pends releases the interrupt for a gap
  task automatic s_gap;
    rw(0, MIC_REG_IEN, 8'h05);
    src = 5'h11;
    cyc(1);
    src = 5'h01;
    wait_int(1'b1);
    rw(0, MIC_REG_MODE, 8'h10);
    wait_int(1'b1);
    cyc(1);
    check({7'h00, low_len == MIC_GAP_CYC}, 8'h01);
    rw(1, MIC_REG_MODE, 8'h01);
    src = 5'h00;
    rw(0, MIC_REG_MODE, 8'h01);
    wait_int(1'b0);
  endtask
  // Clock enable low freezes the flags, so a pulse in that time is lost
  task automatic s_ce;
    rw(0, MIC_REG_IEN, 8'h04);
    ce = 1'b0;
    src[4] = 1'b1;
    cyc(2);
    src[4] = 1'b0;
    ce = 1'b1;
    cyc(3);
    check({7'h00, int_oe}, 8'h00);
    rw(1, MIC_REG_MODE, 8'h00);
  endtask
  // Main sequence
  initial begin
    cyc(20);
    srst = 1'b0;
    cyc(4);
    s_reset();
    s_mode();
    s_dim();
    s_load();
    s_flag(4, 2);
    s_flag(3, 3);
    s_flag(2, -1);
    s_flag(1, 1);
    s_flag(0, 0);
    s_gap();
    s_ce();
    wrap_up();
  end
endmodule // tb
